// File: logic/csi_tx_port_control.sv
// paged control registers and link-side sequencer of one camera serial transmit port
//
// Contract
// RQ1: initial calibration enabled: send calibration at start-up before any high-speed data.
// RQ2: software sets initial calibration when running at the top lane rate.
// RQ3: lane count 00/01/10/11 selects four/three/two/one active data lanes.
// RQ4: lane override 00 normal, 01 data lanes LP00, 11 data and clock LP00.
// RQ5: continuous clock starts only after the first packet has been sent.
// RQ6: output enable turns the port on or off; resets to 0.
// RQ7: software stops forwarding before toggling the output enable.
// RQ8: pass mode 0 any enabled port valid, 1 all enabled ports valid.
// RQ9: calibration pattern alternates starting with 0; invert bit starts with 1.
// RQ10: writing single-calibration bit sends exactly one calibration sequence.
// RQ11: single calibration waits for an idle period on the output.
// RQ12: single-calibration bit self-clears once its sequence has been sent.
// RQ13: calibration sequence is 2 to the 10 bits long.
// RQ14: periodic calibration follows each transmitted frame end packet.
// RQ15: control registers exist per port; paging register picks the copy.
// RQ16: paging bit 4 selects read port; bits 0 and 1 enable writes.
// RQ17: reserved lane override value 10 behaves as normal operation.
`include "csi_tx_cfg.svh"
`timescale 1ns/1ps
module csi_tx_port_control #(
    parameter int NUM_PORTS = 2,
    parameter int ACTIVE_PORT = 0,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic link_clk_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire csi_tx_pkg::stream_word_type stream_in,
    input wire logic stream_valid_in,
    output logic stream_ready_out,
    input wire logic [3:0] rx_enabled_in,
    input wire logic [3:0] rx_video_valid_in,
    output logic pass_out,
    output csi_tx_pkg::link_out_type link_out
);
    localparam int WORD_W = $bits(csi_tx_pkg::stream_word_type);
    localparam int CFG_W = $bits(csi_tx_pkg::tx_cfg_type);
    localparam int CAL_CYCLES = (1 << `CAL_LOG2_BITS) / `LANE_BYTE_BITS;
    localparam int CAL_HOLD = CAL_CYCLES - 1;
    localparam int CNT_W = $clog2(CAL_CYCLES);

    initial
    begin
        if (NUM_PORTS != 2 || ACTIVE_PORT < 0 || ACTIVE_PORT >= NUM_PORTS)
            $error("csi_tx_port_control: paging serves exactly two ports");
    end

    function automatic logic [3:0] lanes_from_count(input logic [1:0] count);
        case (count)
            2'h0: lanes_from_count = 4'hF;
            2'h1: lanes_from_count = 4'h7;
            2'h2: lanes_from_count = 4'h3;
            default: lanes_from_count = 4'h1;
        endcase
    endfunction

    function automatic logic [31:0] byte_mask(input logic [3:0] lanes);
        for (int i = 0; i < 4; i++)
            byte_mask[i*8 +: 8] = {8{lanes[i]}};
    endfunction

    // register side, mclk domain
    logic [7:0] port_sel_reg;
    logic [NUM_PORTS-1:0][7:0] ctl_reg;
    logic [NUM_PORTS-1:0][7:0] ctl_next;
    logic [NUM_PORTS-1:0][7:0] ctl_two_reg;
    logic [NUM_PORTS-1:0][7:0] ctl_two_next;
    logic [7:0] rdata_next;
    logic cal_req_tgl_reg;
    logic cal_done_seen_reg;
    logic word_req_tgl_reg;
    csi_tx_pkg::stream_word_type word_hold_reg;
    logic [1:0] back_sync;
    wire word_ack_m = back_sync[1];
    wire cal_done_m = back_sync[0];
    wire cal_done_pulse = cal_done_m != cal_done_seen_reg;
    wire cal_pending = cal_req_tgl_reg != cal_done_m;
    wire word_busy = word_req_tgl_reg != word_ack_m;
    wire rd_idx = port_sel_reg[`SEL_RD_BIT];
    wire sel_wr = reg_wr_in && reg_addr_in == `ADDR_PORT_SEL;

    genvar k;
    generate
        for (k = 0; k < NUM_PORTS; k++)
        begin : gen_port
            wire wr_en = reg_wr_in && port_sel_reg[`SEL_WR0_BIT + k]; // RQ15 RQ16
            wire hit_ctl = wr_en && reg_addr_in == `ADDR_CTL;
            wire hit_two = wr_en && reg_addr_in == `ADDR_CTL_TWO;
            // set by software wins over the hardware clear in the same cycle
            wire single_set = hit_two && reg_wdata_in[`CTL2_SINGLE_BIT]; // RQ10
            wire single_clr = (k == ACTIVE_PORT) && cal_done_pulse; // RQ12
            wire single_keep = single_set || (ctl_two_reg[k][`CTL2_SINGLE_BIT] && !single_clr);
            wire [7:0] two_base = hit_two ? (reg_wdata_in & `CTL2_MASK) : ctl_two_reg[k];
            assign ctl_next[k] = hit_ctl ? (reg_wdata_in & `CTL_MASK) : ctl_reg[k];
            assign ctl_two_next[k] = (two_base & ~`CTL2_SINGLE_MASK) | (single_keep ? `CTL2_SINGLE_MASK : 8'h00);
        end
    endgenerate

    assign rdata_next = (reg_addr_in == `ADDR_PORT_SEL) ? port_sel_reg :
                        (reg_addr_in == `ADDR_CTL) ? ctl_reg[rd_idx] :
                        (reg_addr_in == `ADDR_CTL_TWO) ? ctl_two_reg[rd_idx] : 8'h00; // RQ16

    csi_tx_pkg::tx_cfg_type cfg_m;
    wire [7:0] act_ctl = ctl_reg[ACTIVE_PORT];
    wire [7:0] act_two = ctl_two_reg[ACTIVE_PORT];
    assign cfg_m.enable = act_ctl[`CTL_ENABLE_BIT]; // RQ6
    assign cfg_m.cont_clock = act_ctl[`CTL_CONT_BIT];
    assign cfg_m.lp_force = act_ctl[`CTL_ULP_LSB +: 2];
    assign cfg_m.lane_count = act_ctl[`CTL_LANE_LSB +: 2];
    assign cfg_m.cal_init = act_ctl[`CTL_CALEN_BIT];
    assign cfg_m.cal_periodic = act_two[`CTL2_PERIODIC_BIT];
    assign cfg_m.cal_invert = act_two[`CTL2_INV_BIT];
    assign cfg_m.pass_all = act_two[`CTL2_PASS_BIT];

    wire [3:0] rx_good = rx_enabled_in & rx_video_valid_in;
    wire pass_any = rx_good != 4'h0;
    wire pass_every = rx_enabled_in != 4'h0 && rx_good == rx_enabled_in;
    wire pass_next = cfg_m.pass_all ? pass_every : pass_any; // RQ8

    // a new single request launches only when none is in flight and none just finished
    wire cal_launch = act_two[`CTL2_SINGLE_BIT] && !cal_pending && !cal_done_pulse; // RQ10

    csi_tx_pkg::stream_word_type fifo_word;
    logic fifo_valid;
    wire word_load = fifo_valid && !word_busy;

    tx_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .wr_data_in(stream_in),
        .wr_valid_in(stream_valid_in),
        .wr_ready_out(stream_ready_out),
        .rd_data_out(fifo_word),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(!word_busy)
    );

    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            port_sel_reg <= `REG_RESET;
            ctl_reg <= {NUM_PORTS{`REG_RESET}}; // RQ6
            ctl_two_reg <= {NUM_PORTS{`REG_RESET}};
            reg_rdata_out <= `REG_RESET;
            pass_out <= 1'b0;
        end
        else
        begin
            port_sel_reg <= sel_wr ? (reg_wdata_in & `SEL_MASK) : port_sel_reg;
            ctl_reg <= ctl_next;
            ctl_two_reg <= ctl_two_next;
            reg_rdata_out <= reg_rd_in ? rdata_next : reg_rdata_out;
            pass_out <= pass_next;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            cal_req_tgl_reg <= 1'b0;
            cal_done_seen_reg <= 1'b0;
            word_req_tgl_reg <= 1'b0;
            word_hold_reg <= '0;
        end
        else
        begin
            cal_req_tgl_reg <= cal_req_tgl_reg ^ cal_launch;
            cal_done_seen_reg <= cal_done_m;
            word_req_tgl_reg <= word_req_tgl_reg ^ word_load;
            word_hold_reg <= word_load ? fifo_word : word_hold_reg;
        end
    end

    // link side, link_clk_in domain
    logic [1:0] link_rst_pipe;
    wire link_rst_n = link_rst_pipe[1];
    always_ff @(posedge link_clk_in)
    begin
        link_rst_pipe <= {link_rst_pipe[0], reset_n_in};
    end

    logic [CFG_W+1:0] fwd_sync;
    csi_tx_pkg::tx_cfg_type cfg_l;
    assign cfg_l = fwd_sync[CFG_W+1:2];
    wire word_req_l = fwd_sync[1];
    wire cal_req_l = fwd_sync[0];

    // the config word is quasi-static; bits may settle one link cycle apart after a write
    sync2 #(
        .WIDTH(CFG_W + 2)
    ) u_fwd_sync (
        .clk_in(link_clk_in),
        .reset_n_in(link_rst_n),
        .d_in({cfg_m, word_req_tgl_reg, cal_req_tgl_reg}),
        .q_out(fwd_sync)
    );

    csi_tx_pkg::link_state_type state_reg;
    csi_tx_pkg::link_state_type state_next;
    logic [CNT_W-1:0] cal_cnt_reg;
    logic word_ack_tgl_reg;
    logic cal_done_tgl_reg;
    logic periodic_due_reg;
    logic cal_single_reg;
    logic first_sent_reg;
    csi_tx_pkg::link_out_type link_out_next;
    logic take_word;
    logic start_single;
    logic start_periodic;

    sync2 #(
        .WIDTH(2)
    ) u_back_sync (
        .clk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .d_in({word_ack_tgl_reg, cal_done_tgl_reg}),
        .q_out(back_sync)
    );

    wire word_avail = word_req_l != word_ack_tgl_reg;
    wire single_due = cal_req_l != cal_done_tgl_reg;
    wire in_cal = state_reg == csi_tx_pkg::ST_CAL || state_reg == csi_tx_pkg::ST_INIT_CAL;
    wire cal_last = cal_cnt_reg == CNT_W'(CAL_HOLD);
    wire cal_finish = state_reg == csi_tx_pkg::ST_CAL && cal_last && cfg_l.enable;
    wire lp_data = cfg_l.lp_force == `ULP_DATA_ONLY || cfg_l.lp_force == `ULP_DATA_CLOCK; // RQ4 RQ17
    wire lp_clock = cfg_l.lp_force == `ULP_DATA_CLOCK; // RQ4 RQ17
    wire [3:0] lanes = lanes_from_count(cfg_l.lane_count); // RQ3
    wire [7:0] cal_byte = cfg_l.cal_invert ? ~`CAL_PATTERN : `CAL_PATTERN; // RQ9
    wire next_cal = state_next == csi_tx_pkg::ST_CAL || state_next == csi_tx_pkg::ST_INIT_CAL;

    always_comb
    begin
        state_next = state_reg;
        take_word = 1'b0;
        start_single = 1'b0;
        start_periodic = 1'b0;
        case (state_reg)
            csi_tx_pkg::ST_OFF:
                if (cfg_l.enable)
                    state_next = cfg_l.cal_init ? csi_tx_pkg::ST_INIT_CAL : csi_tx_pkg::ST_IDLE; // RQ1
            csi_tx_pkg::ST_INIT_CAL, csi_tx_pkg::ST_CAL:
                if (!cfg_l.enable)
                    state_next = csi_tx_pkg::ST_OFF;
                else if (cal_last)
                    state_next = csi_tx_pkg::ST_IDLE; // RQ13
            csi_tx_pkg::ST_IDLE, csi_tx_pkg::ST_DATA:
                if (!cfg_l.enable)
                    state_next = csi_tx_pkg::ST_OFF; // RQ6
                else if (lp_data)
                    state_next = csi_tx_pkg::ST_IDLE;
                else if (periodic_due_reg)
                begin
                    state_next = csi_tx_pkg::ST_CAL; // RQ14
                    start_periodic = 1'b1;
                end
                else if (word_avail)
                begin
                    state_next = csi_tx_pkg::ST_DATA;
                    take_word = 1'b1;
                end
                else if (single_due)
                begin
                    state_next = csi_tx_pkg::ST_CAL; // RQ11
                    start_single = 1'b1;
                end
                else
                    state_next = csi_tx_pkg::ST_IDLE;
            default:
                state_next = csi_tx_pkg::ST_OFF;
        endcase
    end

    assign link_out_next.hs_valid = take_word || next_cal;
    assign link_out_next.cal_active = next_cal;
    assign link_out_next.lanes_active = cfg_l.enable ? lanes : 4'h0; // RQ3
    assign link_out_next.lp00_data = lp_data;
    assign link_out_next.lp00_clock = lp_clock;
    assign link_out_next.clock_continuous = cfg_l.enable && cfg_l.cont_clock && first_sent_reg; // RQ5
    assign link_out_next.lane_bytes = take_word ? (word_hold_reg.data & byte_mask(lanes)) :
                                      next_cal ? ({4{cal_byte}} & byte_mask(lanes)) : 32'h0000_0000; // RQ9

    always_ff @(posedge link_clk_in)
    begin
        if (!link_rst_n)
        begin
            state_reg <= csi_tx_pkg::ST_OFF;
            cal_cnt_reg <= '0;
            link_out <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cal_cnt_reg <= (in_cal && !cal_last) ? cal_cnt_reg + CNT_W'(1) : '0;
            link_out <= link_out_next;
        end
    end

    always_ff @(posedge link_clk_in)
    begin
        if (!link_rst_n)
        begin
            word_ack_tgl_reg <= 1'b0;
            cal_done_tgl_reg <= 1'b0;
            periodic_due_reg <= 1'b0;
            cal_single_reg <= 1'b0;
            first_sent_reg <= 1'b0;
        end
        else
        begin
            word_ack_tgl_reg <= word_ack_tgl_reg ^ take_word;
            cal_done_tgl_reg <= (cal_finish && cal_single_reg) ? cal_req_l : cal_done_tgl_reg; // RQ12
            periodic_due_reg <= (take_word && word_hold_reg.frame_end && cfg_l.cal_periodic) ||
                                (periodic_due_reg && !start_periodic && cfg_l.enable); // RQ14
            cal_single_reg <= start_single || (cal_single_reg && in_cal);
            first_sent_reg <= cfg_l.enable && (first_sent_reg || take_word); // RQ5
        end
    end

    a_enable_reset: assert property (@(posedge mclk_in) !reset_n_in |=> ctl_reg[ACTIVE_PORT][`CTL_ENABLE_BIT] == 1'b0) // RQ6
        else $error("enable bit not cleared by reset");
    a_page_write_gate: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        reg_wr_in && !port_sel_reg[`SEL_WR0_BIT + 1] |=> ctl_reg[1] == $past(ctl_reg[1])) // RQ15
        else $error("unpaged copy changed on write");
    a_page_read_sel: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        reg_rd_in && reg_addr_in == `ADDR_CTL && port_sel_reg[`SEL_RD_BIT] |=> reg_rdata_out == $past(ctl_reg[1])) // RQ16
        else $error("read did not return selected copy");
    a_single_clear: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $fell(ctl_two_reg[ACTIVE_PORT][`CTL2_SINGLE_BIT]) |-> $past(cal_done_pulse)) // RQ12
        else $error("single bit cleared without a finished sequence");
    a_pass_all_mode: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cfg_m.pass_all && rx_enabled_in == 4'hF && rx_video_valid_in != 4'hF |=> !pass_out) // RQ8
        else $error("pass raised while an enabled port lacks video");
    a_pass_any_mode: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !cfg_m.pass_all && (rx_enabled_in & rx_video_valid_in) != 4'h0 |=> pass_out) // RQ8
        else $error("pass missing with one valid port");
    a_init_cal_first: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        state_reg == csi_tx_pkg::ST_OFF && cfg_l.enable && cfg_l.cal_init |=> link_out.cal_active && !take_word) // RQ1
        else $error("initial calibration not sent first");
    a_cal_length: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        $rose(link_out.cal_active) |-> ##CAL_HOLD (link_out.cal_active ##1 !link_out.cal_active)) // RQ13
        else $error("calibration length wrong");
    a_cal_pattern: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        link_out.cal_active && link_out.lanes_active[0] |-> link_out.lane_bytes[7:0] == $past(cal_byte)) // RQ9
        else $error("calibration pattern wrong");
    a_single_idle: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        start_single |-> !word_avail) // RQ11
        else $error("single calibration cut into data");
    a_periodic_fe: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        take_word && word_hold_reg.frame_end && cfg_l.cal_periodic && cfg_l.enable && !lp_data
        |-> ##[1:3] link_out.cal_active) // RQ14
        else $error("no calibration after frame end");
    a_cont_clock: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        link_out.clock_continuous |-> $past(first_sent_reg)) // RQ5
        else $error("continuous clock before first packet");
    a_lp_reserved: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        cfg_l.lp_force == 2'h2 |=> !link_out.lp00_data && !link_out.lp00_clock) // RQ17
        else $error("reserved override forced a lane");
    a_lane_one: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        cfg_l.enable && cfg_l.lane_count == 2'h3 |=> link_out.lanes_active == 4'h1) // RQ3
        else $error("lane count decode wrong");
endmodule

// File: logic/csi_tx_cfg.svh
// register map, field positions and fixed figures of the transmit port control
`ifndef CSI_TX_CFG_SVH
`define CSI_TX_CFG_SVH
`define ADDR_PORT_SEL 8'h32
`define ADDR_CTL 8'h33
`define ADDR_CTL_TWO 8'h34
`define SEL_WR0_BIT 0
`define SEL_RD_BIT 4
`define SEL_MASK 8'h13
`define REG_RESET 8'h00
`define CTL_MASK 8'h7F
`define CTL_ENABLE_BIT 0
`define CTL_CONT_BIT 1
`define CTL_ULP_LSB 2
`define CTL_LANE_LSB 4
`define CTL_CALEN_BIT 6
`define CTL2_MASK 8'h0F
`define CTL2_PERIODIC_BIT 0
`define CTL2_SINGLE_BIT 1
`define CTL2_SINGLE_MASK 8'h02
`define CTL2_INV_BIT 2
`define CTL2_PASS_BIT 3
`define ULP_DATA_ONLY 2'h1
`define ULP_DATA_CLOCK 2'h3
`define CAL_LOG2_BITS 10
`define LANE_BYTE_BITS 8
`define CAL_PATTERN 8'hAA
`endif

// File: logic/csi_tx_pkg.sv
// types shared by the transmit port control
package csi_tx_pkg;
    typedef enum logic [2:0] {ST_OFF, ST_INIT_CAL, ST_IDLE, ST_DATA, ST_CAL} link_state_type;
    typedef struct packed {
        logic frame_end;
        logic [31:0] data;
    } stream_word_type;
    typedef struct packed {
        logic enable;
        logic cont_clock;
        logic [1:0] lp_force;
        logic [1:0] lane_count;
        logic cal_init;
        logic cal_periodic;
        logic cal_invert;
        logic pass_all;
    } tx_cfg_type;
    typedef struct packed {
        logic hs_valid;
        logic cal_active;
        logic [3:0] lanes_active;
        logic lp00_data;
        logic lp00_clock;
        logic clock_continuous;
        logic [31:0] lane_bytes;
    } link_out_type;
endpackage

// File: logic/sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] stage_reg;

    initial
    begin
        if (WIDTH < 1)
            $error("sync2: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            stage_reg <= '0;
            q_out <= '0;
        end
        else
        begin
            stage_reg <= d_in;
            q_out <= stage_reg;
        end
    end
endmodule

// File: logic/tx_fifo.sv
// synchronous valid/ready fifo for the outgoing stream words
`timescale 1ns/1ps
module tx_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = wr_valid_in && wr_ready_out;
    wire pop = rd_valid_out && rd_ready_in;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("tx_fifo: DEPTH must be a power of two, at least 2");
    end

    assign wr_ready_out = count_reg != (AW + 1)'(DEPTH);
    assign rd_valid_out = count_reg != '0;
    assign rd_data_out = mem[rd_ptr_reg];

    always_ff @(posedge mclk_in)
    begin
        if (push)
            mem[wr_ptr_reg] <= wr_data_in;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

// File: bench/rx_sink.sv
// receiving-end model of the transmit port output: records data words and calibration bursts
`timescale 1ns/1ps
module rx_sink (
    input wire logic link_clk_in,
    input wire csi_tx_pkg::link_out_type link_in
);
    logic [31:0] words[$];
    int cal_run = 0;
    int cal_last = 0;
    int bursts = 0;
    int data_at_first = -1;
    logic [7:0] cal_byte = 8'h00;
    logic cont_in_cal = 1'b0;
    // a pure receiver: it never stalls, like the real processor input
    always @(posedge link_clk_in)
    begin
        if (link_in.hs_valid && link_in.cal_active)
        begin
            cal_run++;
            cal_byte = link_in.lane_bytes[7:0];
            cont_in_cal = link_in.clock_continuous;
        end
        else
        begin
            if (cal_run != 0)
            begin
                cal_last = cal_run;
                bursts++;
                if (bursts == 1)
                    data_at_first = words.size();
            end
            cal_run = 0;
            if (link_in.hs_valid)
                words.push_back(link_in.lane_bytes);
        end
    end
endmodule

// File: bench/tb_csi_tx_port_control.sv
// self-checking bench of the transmit port control
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb_csi_tx_port_control;
    logic mclk_in = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    csi_tx_pkg::stream_word_type stream_in = '0;
    logic stream_valid_in = 1'b0;
    logic stream_ready_out;
    logic [3:0] rx_en = 4'h0;
    logic [3:0] rx_vid = 4'h0;
    logic pass_out;
    csi_tx_pkg::link_out_type link_out;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    int seed = 32'h4D33F8B3;
    logic [31:0] sent[$];
    logic [7:0] v;

    csi_tx_port_control i_csi_tx_port_control (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .link_clk_in(link_clk), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .stream_in(stream_in), .stream_valid_in(stream_valid_in), .stream_ready_out(stream_ready_out),
        .rx_enabled_in(rx_en), .rx_video_valid_in(rx_vid), .pass_out(pass_out), .link_out(link_out));
    rx_sink i_rx_sink (.link_clk_in(link_clk), .link_in(link_out));

    always #4 mclk_in = ~mclk_in;
    initial
    begin
        #3.3;
        forever #15 link_clk = ~link_clk;
    end

    function automatic logic exp_pass(input logic [3:0] en, input logic [3:0] vid, input logic all);
        return all ? (en != 4'h0 && (en & vid) == en) : ((en & vid) != 4'h0);
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %0h seen %0h", n, e, g);
            fails++;
        end
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge mclk_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge mclk_in);
        reg_rd_in = 1'b0;
        `CHK(n, e, reg_rdata_out);
    endtask

    task automatic push(input logic fe, input logic [31:0] d);
        @(negedge mclk_in);
        stream_in = {fe, d};
        stream_valid_in = 1'b1;
        for (int i = 0; i < 3000 && stream_ready_out !== 1'b1; i++)
            @(negedge mclk_in);
        @(negedge mclk_in);
        stream_valid_in = 1'b0;
        sent.push_back(d);
    endtask

    task automatic wait_for(input int kind, input int n);
        for (int i = 0; i < 3000; i++)
        begin
            if ((kind == 0 ? i_rx_sink.bursts : i_rx_sink.words.size()) >= n)
                break;
            @(posedge mclk_in);
        end
    endtask

    task automatic cmp_words();
        wait_for(1, sent.size());
        foreach (sent[i])
            `CHK("word", sent[i], i_rx_sink.words[i]);
        sent.delete();
        i_rx_sink.words.delete();
    endtask

    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        // held past four link edges so the link side leaves reset as well
        repeat (16) @(posedge mclk_in);
        @(negedge mclk_in);
        reset_n_in = 1'b1;
        rdchk("ctl", 8'h33, 8'h00);
        rdchk("ctl_two", 8'h34, 8'h00);
        rdchk("unmapped", 8'h40, 8'h00);
        v = 8'($random(seed));
        wr(8'h32, 8'h02);
        wr(8'h33, v);
        rdchk("port0 kept", 8'h33, 8'h00);
        wr(8'h32, 8'hFF);
        rdchk("sel", 8'h32, 8'h13);
        wr(8'h32, 8'h12);
        rdchk("port1", 8'h33, v & 8'h7F);
        wr(8'h32, 8'h01);
        $display("test registers done");
        for (int k = 0; k < 12 && stream_ready_out === 1'b1; k++)
            push(1'b0, $random(seed));
        `CHK("full", 1'b0, stream_ready_out);
        wr(8'h33, 8'h43);
        wait_for(0, 1);
        `CHK("init length", 128, i_rx_sink.cal_last);
        `CHK("init first", 0, i_rx_sink.data_at_first);
        `CHK("pattern", 8'hAA, i_rx_sink.cal_byte);
        `CHK("clock before", 1'b0, i_rx_sink.cont_in_cal);
        cmp_words();
        `CHK("clock after", 1'b1, link_out.clock_continuous);
        $display("test stream done");
        for (int e = 0; e < 4; e++)
        begin
            wr(8'h33, 8'(8'h01 | (e << 4)));
            repeat (30) @(posedge mclk_in);
            `CHK("lanes", 4'hF >> e, link_out.lanes_active);
        end
        for (int u = 0; u < 4; u++)
        begin
            wr(8'h33, 8'(8'h01 | (u << 2)));
            repeat (30) @(posedge mclk_in);
            `CHK("lp00 data", u[0], link_out.lp00_data);
            `CHK("lp00 clock", u == 3, link_out.lp00_clock);
        end
        wr(8'h33, 8'h00);
        repeat (30) @(posedge mclk_in);
        `CHK("disabled", 4'h0, link_out.lanes_active);
        wr(8'h33, 8'h01);
        $display("test lanes done");
        wr(8'h34, 8'h06);
        wait_for(0, 2);
        `CHK("single length", 128, i_rx_sink.cal_last);
        `CHK("inverted", 8'h55, i_rx_sink.cal_byte);
        repeat (20) @(posedge mclk_in);
        rdchk("single clear", 8'h34, 8'h04);
        `CHK("one burst", 2, i_rx_sink.bursts);
        wr(8'h34, 8'h01);
        push(1'b1, $random(seed));
        wait_for(0, 3);
        `CHK("periodic", 3, i_rx_sink.bursts);
        `CHK("periodic pattern", 8'hAA, i_rx_sink.cal_byte);
        cmp_words();
        $display("test calibration done");
        for (int k = 0; k < 24; k++)
        begin
            if (k % 8 == 0)
                wr(8'h34, 8'(k & 8));
            @(negedge mclk_in);
            rx_en = (k % 8 == 0) ? 4'h0 : 4'($random(seed));
            rx_vid = (k % 4 == 1) ? rx_en : 4'($random(seed));
            @(negedge mclk_in);
            `CHK("pass", exp_pass(rx_en, rx_vid, k[3]), pass_out);
        end
        $display("test pass done");
        stop_test();
    end
endmodule
